// file: design/ssw_param_write.sv
`timescale 1ns/1ps

// Function
// - 0x06/0x41 write one 16-bit value; no 32-bit mode for them.
// - Single write with address top bit set answers address error, changes nothing.
// - 16-bit value into signed parameter is sign-extended with 0xFFFF or 0x0000.
// - Commit only when extended value is in range and parameter changeable.
// - Unsigned parameters in 16-bit mode get zero upper half, no extension.
// - 0x10/0x43 write consecutive function or control parameters, 16 or 32 bit.
// - Top bit of start address selects 32-bit mode.
// - In 32-bit mode register count is twice the parameter count.
// - In 32-bit mode each value is two consecutive 16-bit registers.
// - Good multi write echoes slave, command, start, count, then check code.
// - Failed writes answer with an exception frame; a bad check code or an overrun frame stays silent.
// - 32-bit mode accepts in-range values for 16- and 32-bit parameters.
// - Function parameter run: any failure changes nothing and reports error.
// - Control parameter run: keep writes before first failure, skip rest, error.
// - For 0x06 and 0x10 a save-select input decides power-loss retention.
// - Check code is CRC-16, init 0xFFFF, poly 0xA001, low byte sent first.
// - Class I parameters are signed, class II unsigned; class steers extension.
module ssw_param_write
	import ssw_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Configuration
	input wire logic [7:0] slaveAddr,
	input wire logic powerOffSaveSelect,
	// Received byte stream
	input wire ssw_pkg::ssw_rx_t rx,
	// Response byte stream
	input wire logic txReady,
	output ssw_pkg::ssw_tx_t tx,
	// Parameter store
	output logic [15:0] queryAddr,
	input wire ssw_pkg::ssw_attr_t attr,
	output ssw_pkg::ssw_wr_t wr,
	// Status
	output logic busy
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ssw_state_t state_q, state_d;
	logic [5:0] len_q, len_d;
	logic ovf_q, ovf_d;
	logic [2:0] idx_q, idx_d;
	logic [2:0] lastIdx_q, lastIdx_d;
	logic pass_q, pass_d;
	logic ctrl_q, ctrl_d;
	logic mode32_q, mode32_d;
	logic single_q, single_d;
	logic isExc_q, isExc_d;
	logic [7:0] errCode_q, errCode_d;
	logic [3:0] txIdx_q, txIdx_d;
	logic [15:0] base_q, base_d;
	logic [15:0] queryAddr_q, queryAddr_d;
	ssw_tx_t tx_q, tx_d;
	ssw_wr_t wr_q, wr_d;
	logic busy_q, busy_d;
	logic [7:0] frameBuf [BUF_DEPTH];

	// ------------------------------------------------------------
	// Frame capture and check code
	// ------------------------------------------------------------
	logic rxTake;
	logic [15:0] rxCrc;
	logic [15:0] txCrc;
	logic txCrcClr;
	logic txCrcEn;
	logic [7:0] txBody;

	// Store while idle; the byte that fills the last buffer slot marks the frame as lost
	assign rxTake = (state_q == ST_RECV) && rx.valid && !ovf_q;

	ssw_crc16 rxCrcUnit (
		.mclk(mclk),
		.reset(reset),
		.clear(len_q == 6'd0),
		.enable(rxTake),
		.data(rx.data),
		.crc(rxCrc)
	);

	ssw_crc16 txCrcUnit (
		.mclk(mclk),
		.reset(reset),
		.clear(txCrcClr),
		.enable(txCrcEn),
		.data(txBody),
		.crc(txCrc)
	);

	// Frame buffer holds data only, no reset needed
	always_ff @(posedge mclk)
	begin
		if (rxTake && len_q <= BUF_LAST)
			frameBuf[len_q] <= rx.data;
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	logic [7:0] cmd;
	logic [15:0] startAddr;
	logic [15:0] regCount;
	logic [7:0] byteCount;
	logic cmdOne;
	logic cmdMany;
	logic [15:0] manyParams;
	logic manyShapeOk;

	assign cmd = frameBuf[1];
	assign startAddr = {frameBuf[2], frameBuf[3]};
	assign regCount = {frameBuf[4], frameBuf[5]};
	assign byteCount = frameBuf[6];
	assign cmdOne = (cmd == CMD_WR_ONE_KEEP) || (cmd == CMD_WR_ONE_VOLATILE);
	assign cmdMany = (cmd == CMD_WR_MANY_KEEP) || (cmd == CMD_WR_MANY_VOLATILE);
	assign manyParams = startAddr[MODE32_BIT] ? (regCount >> 1) : regCount;
	// Count, byte count and length must agree; 32-bit count must be even
	assign manyShapeOk = (regCount != 16'h0000) && (manyParams <= MAX_PARAMS)
		&& !(startAddr[MODE32_BIT] && regCount[0])
		&& ({regCount[14:0], 1'b0} == {8'h00, byteCount})
		&& ({3'b000, len_q} == MANY_OVERHEAD + {1'b0, byteCount});

	// ------------------------------------------------------------
	// Entry value and acceptance
	// ------------------------------------------------------------
	logic [5:0] ptr;
	logic [15:0] hiWord;
	logic [15:0] loWord;
	logic [31:0] value;
	logic inRange;
	logic entryOk;

	// Locate entry: 16-bit units step by 2 bytes, 32-bit units by 4
	assign ptr = single_q ? ONE_VALUE_POS
		: (MANY_DATA_POS + (mode32_q ? {1'b0, idx_q, 2'b00} : {2'b00, idx_q, 1'b0}));
	assign hiWord = {frameBuf[ptr], frameBuf[ptr + 6'd1]};
	assign loWord = {frameBuf[ptr + 6'd2], frameBuf[ptr + 6'd3]};

	// Widen a 16-bit value by class, or take the full 32-bit unit
	always_comb
	begin
		if (mode32_q)
			value = {hiWord, loWord};
		else if (attr.classSigned && hiWord[15])
			value = {SIGN_FILL, hiWord};
		else
			value = {ZERO_FILL, hiWord};
	end

	// Signed or unsigned range compare by class
	assign inRange = attr.classSigned
		? ($signed(value) >= $signed(attr.minVal) && $signed(value) <= $signed(attr.maxVal))
		: (value >= attr.minVal && value <= attr.maxVal);
	assign entryOk = attr.exists && attr.changeable && inRange;

	// ------------------------------------------------------------
	// Response body bytes
	// ------------------------------------------------------------
	always_comb
	begin
		if (isExc_q)
		begin
			unique case (txIdx_q)
				4'h0: txBody = frameBuf[0];
				4'h1: txBody = frameBuf[1] | EXC_FLAG;
				default: txBody = errCode_q;
			endcase
		end
		else
		begin
			txBody = frameBuf[txIdx_q[2:0]];
		end
	end

	// ------------------------------------------------------------
	// Control sequence
	// ------------------------------------------------------------
	logic [3:0] bodyLen;
	logic txLoad;
	logic ctrlNow;
	logic lastEntry;

	assign bodyLen = isExc_q ? EXC_LEN : ECHO_LEN;
	assign txLoad = (state_q == ST_SEND) && (!tx_q.valid || txReady);
	assign txCrcClr = (state_q == ST_RESP);
	assign txCrcEn = txLoad && (txIdx_q < bodyLen);
	assign ctrlNow = (idx_q == 3'd0) ? attr.isControl : ctrl_q;
	assign lastEntry = (idx_q == lastIdx_q);

	// Next-state and output computation
	always_comb
	begin
		state_d = state_q;
		len_d = len_q;
		ovf_d = ovf_q;
		idx_d = idx_q;
		lastIdx_d = lastIdx_q;
		pass_d = pass_q;
		ctrl_d = ctrl_q;
		mode32_d = mode32_q;
		single_d = single_q;
		isExc_d = isExc_q;
		errCode_d = errCode_q;
		txIdx_d = txIdx_q;
		base_d = base_q;
		queryAddr_d = queryAddr_q;
		tx_d = tx_q;
		wr_d = wr_q;
		wr_d.valid = 1'b0;
		busy_d = (state_q != ST_RECV);
		unique case (state_q)
			ST_RECV:
			begin
				if (rxTake)
				begin
					if (len_q == BUF_LAST)
						ovf_d = 1'b1;
					else
						len_d = len_q + 6'd1;
				end
				if (rx.frameEnd && (len_q != 6'd0 || rx.valid))
					state_d = ST_CHECK;
			end
			ST_CHECK:
			begin
				idx_d = 3'd0;
				pass_d = 1'b0;
				isExc_d = 1'b0;
				single_d = cmdOne;
				mode32_d = cmdMany && startAddr[MODE32_BIT];
				base_d = startAddr & ADDR_MASK;
				queryAddr_d = startAddr & ADDR_MASK;
				lastIdx_d = cmdOne ? 3'd0 : 3'(manyParams - 16'h0001);
				state_d = ST_RECV;
				len_d = 6'd0;
				ovf_d = 1'b0;
				// Bad check code, foreign address or other command: silent
				if (rxCrc == CRC_RESIDUE && !ovf_q && len_q >= MIN_FRAME
					&& frameBuf[0] == slaveAddr)
				begin
					if (cmdOne && startAddr[MODE32_BIT])
					begin
						isExc_d = 1'b1;
						errCode_d = EXC_BAD_ADDR;
						state_d = ST_RESP;
					end
					else if ((cmdOne && len_q != ONE_FRAME_LEN) || (cmdMany && !manyShapeOk))
					begin
						isExc_d = 1'b1;
						errCode_d = EXC_BAD_VALUE;
						state_d = ST_RESP;
					end
					else if (cmdOne || cmdMany)
					begin
						state_d = ST_VALID;
					end
				end
			end
			ST_VALID:
			begin
				ctrl_d = ctrlNow;
				wr_d.addr = queryAddr_q;
				wr_d.data = value;
				wr_d.persist = ((cmd == CMD_WR_ONE_KEEP) || (cmd == CMD_WR_MANY_KEEP))
					&& powerOffSaveSelect;
				if (!entryOk)
				begin
					// Control runs keep earlier commits; function runs had none
					isExc_d = 1'b1;
					errCode_d = attr.exists ? EXC_BAD_VALUE : EXC_BAD_ADDR;
					state_d = ST_RESP;
				end
				else
				begin
					wr_d.valid = pass_q || ctrlNow;
					if (!lastEntry)
					begin
						idx_d = idx_q + 3'd1;
						queryAddr_d = queryAddr_q + 16'h0001;
					end
					else if (pass_q || ctrlNow)
					begin
						state_d = ST_RESP;
					end
					else
					begin
						// All function entries passed: second pass commits them
						pass_d = 1'b1;
						idx_d = 3'd0;
						queryAddr_d = base_q;
					end
				end
			end
			ST_RESP:
			begin
				txIdx_d = 4'h0;
				state_d = ST_SEND;
			end
			ST_SEND:
			begin
				if (txLoad)
				begin
					if (tx_q.valid && tx_q.last)
					begin
						tx_d.valid = 1'b0;
						tx_d.last = 1'b0;
						state_d = ST_RECV;
					end
					else
					begin
						tx_d.valid = 1'b1;
						txIdx_d = txIdx_q + 4'h1;
						if (txIdx_q < bodyLen)
							tx_d.data = txBody;
						else if (txIdx_q == bodyLen)
							tx_d.data = txCrc[7:0];
						else
							tx_d.data = txCrc[15:8];
						tx_d.last = (txIdx_q == bodyLen + 4'h1);
					end
				end
			end
			default:
			begin
				state_d = ST_RECV;
			end
		endcase
	end

	// Register all control state
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= ST_RECV;
			len_q <= 6'd0;
			ovf_q <= 1'b0;
			idx_q <= 3'd0;
			lastIdx_q <= 3'd0;
			pass_q <= 1'b0;
			ctrl_q <= 1'b0;
			mode32_q <= 1'b0;
			single_q <= 1'b0;
			isExc_q <= 1'b0;
			errCode_q <= 8'h00;
			txIdx_q <= 4'h0;
			base_q <= 16'h0000;
			queryAddr_q <= 16'h0000;
			tx_q <= '0;
			wr_q <= '0;
			busy_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			len_q <= len_d;
			ovf_q <= ovf_d;
			idx_q <= idx_d;
			lastIdx_q <= lastIdx_d;
			pass_q <= pass_d;
			ctrl_q <= ctrl_d;
			mode32_q <= mode32_d;
			single_q <= single_d;
			isExc_q <= isExc_d;
			errCode_q <= errCode_d;
			txIdx_q <= txIdx_d;
			base_q <= base_d;
			queryAddr_q <= queryAddr_d;
			tx_q <= tx_d;
			wr_q <= wr_d;
			busy_q <= busy_d;
		end
	end

	// Outputs straight from flops
	assign tx = tx_q;
	assign wr = wr_q;
	assign queryAddr = queryAddr_q;
	assign busy = busy_q;

endmodule : ssw_param_write

// file: design/ssw_pkg.sv
package ssw_pkg;

	// ------------------------------------------------------------
	// Command codes and response encoding
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_WR_ONE_KEEP = 8'h06;
	localparam logic [7:0] CMD_WR_ONE_VOLATILE = 8'h41;
	localparam logic [7:0] CMD_WR_MANY_KEEP = 8'h10;
	localparam logic [7:0] CMD_WR_MANY_VOLATILE = 8'h43;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
	localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int BUF_DEPTH = 48;
	localparam logic [5:0] BUF_LAST = 6'd47;
	localparam logic [5:0] MIN_FRAME = 6'd4;
	localparam logic [5:0] ONE_FRAME_LEN = 6'd8;
	localparam logic [5:0] ONE_VALUE_POS = 6'd4;
	localparam logic [5:0] MANY_DATA_POS = 6'd7;
	localparam logic [8:0] MANY_OVERHEAD = 9'd9;
	localparam logic [15:0] MAX_PARAMS = 16'h0008;
	localparam int MODE32_BIT = 15;
	localparam logic [15:0] ADDR_MASK = 16'h7FFF;
	localparam logic [3:0] ECHO_LEN = 4'h6;
	localparam logic [3:0] EXC_LEN = 4'h3;

	// ------------------------------------------------------------
	// Value extension and check code
	// ------------------------------------------------------------
	localparam logic [15:0] SIGN_FILL = 16'hFFFF;
	localparam logic [15:0] ZERO_FILL = 16'h0000;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_RECV, ST_CHECK, ST_VALID, ST_RESP, ST_SEND} ssw_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic frameEnd;
	} ssw_rx_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} ssw_tx_t;

	typedef struct packed {
		logic exists;
		logic changeable;
		logic classSigned;
		logic isControl;
		logic [31:0] minVal;
		logic [31:0] maxVal;
	} ssw_attr_t;

	typedef struct packed {
		logic valid;
		logic persist;
		logic [15:0] addr;
		logic [31:0] data;
	} ssw_wr_t;

endpackage : ssw_pkg

// file: design/ssw_crc16.sv
`timescale 1ns/1ps

module ssw_crc16
	import ssw_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Byte feed
	input wire logic clear,
	input wire logic enable,
	input wire logic [7:0] data,
	// Running check code
	output logic [15:0] crc
);

	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic [15:0] seed;

	// Reflected shift, low bit first, one byte per enable
	always_comb
	begin
		seed = clear ? CRC_INIT : crc_q;
		crc_d = seed;
		if (enable)
		begin
			crc_d = seed ^ {8'h00, data};
			for (int i = 0; i < 8; i++)
			begin
				crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
			end
		end
	end

	// Register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			crc_q <= CRC_INIT;
		else
			crc_q <= crc_d;
	end

	assign crc = crc_q;

endmodule : ssw_crc16

// file: sim/ssw_param_write_properties.sv
`timescale 1ns/1ps

module ssw_param_write_properties
	import ssw_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Watched ports
	input wire logic [7:0] slaveAddr,
	input wire logic powerOffSaveSelect,
	input wire logic txReady,
	input wire ssw_pkg::ssw_tx_t tx,
	input wire ssw_pkg::ssw_wr_t wr,
	input wire logic busy
);
	// ------------------------------------------------------------
	// Reply stream checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// Reply start and reply hand-off
	sequence s_txStart;
		!tx.valid ##1 tx.valid;
	endsequence
	sequence s_txDone;
		tx.valid && tx.last && txReady;
	endsequence

	a_tx_hold: assert property (tx.valid && !txReady |=> tx.valid && $stable(tx.data))
		else $error("Offered reply byte changed before it was taken");
	a_first_slave: assert property (s_txStart |-> tx.data == slaveAddr)
		else $error("Reply does not open with the station address");
	a_done_release: assert property (s_txDone |=> !tx.valid)
		else $error("Reply continued after its last byte");
	a_last_valid: assert property (tx.last |-> tx.valid)
		else $error("Last marker without a byte");
	a_send_busy: assert property (tx.valid |-> busy)
		else $error("Reply offered while idle");

	// ------------------------------------------------------------
	// Write port checks
	// ------------------------------------------------------------
	a_persist_sel: assert property (wr.valid && wr.persist |-> powerOffSaveSelect)
		else $error("Persistent write without save select");
	a_addr_masked: assert property (wr.valid |-> !wr.addr[15])
		else $error("Mode bit leaked into write address");
	a_wr_quiet: assert property (wr.valid |-> !tx.valid)
		else $error("Write during reply");
endmodule : ssw_param_write_properties

// file: sim/ssw_param_store_model.sv
`timescale 1ns/1ps

module ssw_param_store_model
	import ssw_pkg::*;
(
	// Query from the block
	input wire logic [15:0] queryAddr,
	// Attributes of the queried parameter
	output ssw_pkg::ssw_attr_t attr
);
	// Attribute table: exists, changeable, signed, control, min, max
	always_comb
	begin
		case (queryAddr)
			16'h0200: attr = '{1'b1, 1'b1, 1'b1, 1'b0, 32'hFFFE_0000, 32'h0002_0000};
			16'h0201: attr = '{1'b1, 1'b1, 1'b0, 1'b0, 32'h0000_0000, 32'h0001_0000};
			16'h0202: attr = '{1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0064};
			16'h6400: attr = '{1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_0000, 32'h0000_FFFF};
			16'h6401: attr = '{1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0000, 32'h0000_FFFF};
			default: attr = '0; // Unknown parameter numbers do not exist
		endcase
	end
endmodule : ssw_param_store_model

// file: sim/ssw_param_write_test.sv
`timescale 1ns/1ps

module ssw_param_write_test;
	import ssw_pkg::*;
	typedef logic [7:0] ssw_bq_t[$];
	localparam logic [7:0] SLAVE = 8'h05;
	logic mclk;
	logic reset;
	logic powerOffSaveSelect;
	ssw_rx_t rx;
	logic txReady;
	ssw_tx_t tx;
	logic [15:0] queryAddr;
	ssw_attr_t attr;
	ssw_wr_t wr;
	logic busy;
	ssw_wr_t wrQ[$];
	ssw_bq_t got;
	int mismatches;
	int check_count;

	// ------------------------------------------------------------
	// Clock, design and store
	// ------------------------------------------------------------
	always #12.5 mclk = ~mclk;

	ssw_param_write u_dut (.mclk(mclk), .reset(reset), .slaveAddr(SLAVE),
		.powerOffSaveSelect(powerOffSaveSelect), .rx(rx), .txReady(txReady), .tx(tx),
		.queryAddr(queryAddr), .attr(attr), .wr(wr), .busy(busy));
	ssw_param_store_model u_store (.queryAddr(queryAddr), .attr(attr));

	// Log every committed write, mid-cycle where the pulse has settled
	always @(negedge mclk)
		if (wr.valid === 1'b1)
			wrQ.push_back(wr);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] crc16(input ssw_bq_t q);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// Send a frame with its check code, then take the reply
	task automatic run(input ssw_bq_t req, input bit badCrc, input bit stall);
		logic [15:0] c;
		c = crc16(req);
		req.push_back(c[7:0]);
		req.push_back(c[15:8] ^ {7'h00, badCrc});
		wrQ.delete();
		got.delete();
		foreach (req[i])
		begin
			@(posedge mclk);
			#2 rx = '{1'b1, req[i], i == req.size() - 1};
		end
		@(posedge mclk);
		#2 rx = '0;
		for (int n = 0; n < 200; n++)
		begin
			txReady = stall ? n[0] : 1'b1;
			if (tx.valid === 1'b1 && txReady)
			begin
				got.push_back(tx.data);
				if (tx.last === 1'b1)
					n = 1000;
			end
			@(posedge mclk);
			#2;
		end
		txReady = 1'b1;
	endtask : run

	task automatic respChk(input ssw_bq_t exp);
		logic [15:0] c;
		c = crc16(exp);
		exp.push_back(c[7:0]);
		exp.push_back(c[15:8]);
		chk(got.size(), exp.size(), "reply length");
		foreach (exp[i])
			chk(got[i], exp[i], "reply byte");
	endtask : respChk

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_single_sign;
		powerOffSaveSelect = 1'b0;
		run({SLAVE, 8'h06, 8'h02, 8'h00, 8'hFE, 8'h0C}, 1'b0, 1'b0);
		chk(wrQ.size(), 1, "write count");
		chk(wrQ[0], {1'b1, 1'b0, 16'h0200, 32'hFFFF_FE0C}, "signed fill");
		respChk({SLAVE, 8'h06, 8'h02, 8'h00, 8'hFE, 8'h0C});
		$display("t_single_sign done");
	endtask : t_single_sign

	task automatic t_single_unsigned;
		powerOffSaveSelect = 1'b1;
		run({SLAVE, 8'h41, 8'h02, 8'h01, 8'hFE, 8'h0C}, 1'b0, 1'b0);
		chk(wrQ[0], {1'b1, 1'b0, 16'h0201, 32'h0000_FE0C}, "zero fill");
		respChk({SLAVE, 8'h41, 8'h02, 8'h01, 8'hFE, 8'h0C});
		$display("t_single_unsigned done");
	endtask : t_single_unsigned

	task automatic t_single_badaddr;
		run({SLAVE, 8'h06, 8'h82, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
		chk(wrQ.size(), 0, "no write");
		respChk({SLAVE, 8'h86, 8'h02});
		$display("t_single_badaddr done");
	endtask : t_single_badaddr

	task automatic t_multi32;
		powerOffSaveSelect = 1'b1;
		run({SLAVE, 8'h10, 8'h82, 8'h00, 8'h00, 8'h04, 8'h08, 8'h00, 8'h01, 8'h80, 8'h00,
			8'h00, 8'h00, 8'hFF, 8'hFF}, 1'b0, 1'b1);
		chk(wrQ.size(), 2, "write count");
		chk(wrQ[0], {1'b1, 1'b1, 16'h0200, 32'h0001_8000}, "wide value");
		chk(wrQ[1], {1'b1, 1'b1, 16'h0201, 32'h0000_FFFF}, "next value");
		chk(queryAddr, 16'h0201, "last queried");
		respChk({SLAVE, 8'h10, 8'h82, 8'h00, 8'h00, 8'h04});
		$display("t_multi32 done");
	endtask : t_multi32

	task automatic t_func_fail;
		run({SLAVE, 8'h10, 8'h02, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02,
			8'h00, 8'h65}, 1'b0, 1'b0);
		chk(wrQ.size(), 0, "none kept");
		respChk({SLAVE, 8'h90, 8'h03});
		$display("t_func_fail done");
	endtask : t_func_fail

	task automatic t_ctrl_fail;
		// A clean control run commits in one pass, then a run that fails midway
		powerOffSaveSelect = 1'b1;
		run({SLAVE, 8'h10, 8'h64, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 1'b0, 1'b0);
		chk(wrQ.size(), 1, "ctrl count");
		chk(wrQ[0], {1'b1, 1'b1, 16'h6400, 32'h0000_1234}, "ctrl write");
		respChk({SLAVE, 8'h10, 8'h64, 8'h00, 8'h00, 8'h01});
		run({SLAVE, 8'h43, 8'h64, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02,
			8'h00, 8'h03}, 1'b0, 1'b0);
		chk(wrQ.size(), 1, "prefix kept");
		chk(wrQ[0], {1'b1, 1'b0, 16'h6400, 32'h0000_0001}, "kept write");
		respChk({SLAVE, 8'hC3, 8'h03});
		$display("t_ctrl_fail done");
	endtask : t_ctrl_fail

	task automatic t_bad_crc;
		run({SLAVE, 8'h06, 8'h02, 8'h00, 8'h00, 8'h05}, 1'b1, 1'b0);
		chk(wrQ.size(), 0, "dropped write");
		chk(got.size(), 0, "silent drop");
		chk(busy, 1'b0, "idle after drop");
		$display("t_bad_crc done");
	endtask : t_bad_crc

	task automatic t_refused;
		// Unknown parameter, then a byte count that disagrees with the count
		run({SLAVE, 8'h06, 8'h03, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
		chk(wrQ.size(), 0, "missing param");
		respChk({SLAVE, 8'h86, 8'h02});
		run({SLAVE, 8'h10, 8'h02, 8'h00, 8'h00, 8'h02, 8'h05, 8'h00, 8'h01, 8'h00, 8'h02},
			1'b0, 1'b0);
		chk(wrQ.size(), 0, "bad shape");
		respChk({SLAVE, 8'h90, 8'h03});
		$display("t_refused done");
	endtask : t_refused

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	initial
	begin
		mclk = 1'b0;
		reset = 1'b1;
		rx = '0;
		txReady = 1'b1;
		powerOffSaveSelect = 1'b0;
		mismatches = 0;
		check_count = 0;
		repeat (3) @(posedge mclk);
		#2 reset = 1'b0;
		t_single_sign();
		t_single_unsigned();
		t_single_badaddr();
		t_multi32();
		t_func_fail();
		t_ctrl_fail();
		t_bad_crc();
		t_refused();
		conclude();
	end

	// Watchdog well beyond ten frames of a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		conclude();
	end
endmodule : ssw_param_write_test

bind ssw_param_write ssw_param_write_properties u_props (.mclk(mclk), .reset(reset),
	.slaveAddr(slaveAddr), .powerOffSaveSelect(powerOffSaveSelect), .txReady(txReady),
	.tx(tx), .wr(wr), .busy(busy));
